// >>> dv/cpu_core_state_registers_tb.sv
// Self-checking bench for the core state register file
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"

module cpu_core_state_registers_tb
	import core_state_pkg::*;
;
	logic clk, reset_n, ds_write, ds_read, ds_hit, acc_load, alu_carry, tested_bit;
	logic instr_start, machine_cycle, periph_tick, instr_done, carry, zero;
	logic [7:0] ds_addr, ds_wdata, ds_rdata, branch_offset, acc_value, alu_result, accumulator;
	logic [7:0] rom_byte;
	logic [11:0] pc_target, irq_vector, program_counter, exp_pc;
	logic [11:0] stk[$];
	pc_op_t pc_op;
	flag_op_t flag_op;
	context_t context_now;
	instr_len_t instr_len;
	int seed = 25122;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	logic [7:0] d[5];
	logic [7:0] addrs[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
	pc_op_t ops[5] = '{OP_INC, OP_BRANCH, OP_JUMP, OP_CALL, OP_RET};

	cpu_core_state_registers i_dut (.clk(clk), .reset_n(reset_n), .ds_addr(ds_addr),
		.ds_write(ds_write), .ds_read(ds_read), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata),
		.ds_hit(ds_hit), .pc_op(pc_op), .pc_target(pc_target), .irq_vector(irq_vector),
		.branch_offset(branch_offset), .program_counter(program_counter),
		.acc_load(acc_load), .acc_value(acc_value), .flag_op(flag_op),
		.alu_result(alu_result), .alu_carry(alu_carry), .tested_bit(tested_bit),
		.accumulator(accumulator), .carry(carry), .zero(zero), .context_now(context_now),
		.instr_start(instr_start), .instr_len(instr_len), .machine_cycle(machine_cycle),
		.periph_tick(periph_tick), .instr_done(instr_done));

	prog_mem_model i_rom (.clk(clk), .addr(program_counter), .data(rom_byte));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// Long enough for every scenario below with a wide margin
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end

	task automatic check(input string nm, input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	function automatic logic [11:0] br(input logic [11:0] p, input logic [7:0] o);
		return p + {{4{o[7]}}, o};
	endfunction : br

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic dwrite(input logic [7:0] a, input logic [7:0] v);
		ds_addr = a;
		ds_wdata = v;
		ds_write = 1'b1;
		tick();
		ds_write = 1'b0;
		// Idle edge so a following transfer never re-raises a strobe in the same step
		tick();
	endtask : dwrite

	task automatic dread(input logic [7:0] a, input logic [7:0] e, input logic h);
		ds_addr = a;
		ds_read = 1'b1;
		tick();
		ds_read = 1'b0;
		check("ds_rdata", ds_rdata, e);
		check("ds_hit", ds_hit, h);
		tick();
	endtask : dread

	// Core controls count only on a machine-cycle pulse, so wait for one first
	task automatic op(input pc_op_t p, input flag_op_t f);
		int k;
		k = 0;
		while (machine_cycle !== 1'b1 && k < 40)
		begin
			tick();
			k++;
		end
		pc_op = p;
		flag_op = f;
		tick();
		pc_op = OP_HOLD;
		flag_op = FLAG_NONE;
		acc_load = 1'b0;
		instr_start = 1'b0;
	endtask : op

	task automatic step(input pc_op_t p);
		logic [11:0] e;
		e = exp_pc;
		case (p)
			OP_INC: e = exp_pc + 12'h001;
			OP_BRANCH: e = br(exp_pc, branch_offset);
			OP_JUMP: e = pc_target;
			OP_CALL, OP_IRQ, OP_NMI:
			begin
				stk.push_front(exp_pc);
				if (stk.size() > 6)
					void'(stk.pop_back());
				e = (p == OP_CALL) ? pc_target : (p == OP_IRQ) ? irq_vector : `NMI_VECTOR_DEFAULT;
			end
			OP_RET, OP_INTERRUPT_EXIT_OP: if (stk.size() > 0) e = stk.pop_front();
			default: e = exp_pc;
		endcase
		op(p, flag_op);
		exp_pc = e;
		check("program_counter", program_counter, exp_pc);
	endtask : step

	task automatic flags(input logic c, input logic z);
		check("carry", carry, c);
		check("zero", zero, z);
	endtask : flags

	task automatic pulse_gap(input logic which, output int g);
		g = 0;
		do
		begin
			tick();
			g++;
		end while ((which ? periph_tick : machine_cycle) !== 1'b1 && g < 50);
	endtask : pulse_gap

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{reset_n, ds_write, ds_read, acc_load, alu_carry, tested_bit, instr_start} = '0;
		{ds_addr, ds_wdata, branch_offset, acc_value, alu_result} = '0;
		{pc_target, irq_vector} = '0;
		pc_op = OP_HOLD;
		flag_op = FLAG_NONE;
		instr_len = LEN_SHORT;
		repeat (10) @(posedge clk);
		#1;
		reset_n = 1'b1;
		exp_pc = `RESET_VECTOR_DEFAULT;
		check("pc_reset", program_counter, exp_pc);
		check("ctx_reset", context_now, CTX_NMI);
		// Mapped registers, then an unmapped neighbour that must not answer
		foreach (addrs[i])
		begin
			d[i] = 8'($random(seed));
			dwrite(addrs[i], d[i]);
		end
		foreach (addrs[i]) dread(addrs[i], d[i], 1'b1);
		dwrite(8'h84, 8'ha5);
		dread(8'h84, 8'h00, 1'b0);
		check("accumulator", accumulator, d[4]);
		acc_value = 8'($random(seed));
		acc_load = 1'b1;
		step(OP_INC);
		dread(8'hff, acc_value, 1'b1);
		// Dividers: machine cycle and peripheral tick spacing
		pulse_gap(1'b0, n);
		pulse_gap(1'b0, n);
		check("core_div", 16'(n), 16'd13);
		pulse_gap(1'b1, n);
		pulse_gap(1'b1, n);
		check("periph_div", 16'(n), 16'd12);
		// Flag pairs per context
		alu_result = 8'h00;
		alu_carry = 1'b1;
		flag_op = FLAG_ARITH;
		step(OP_INC);
		flags(1'b1, 1'b1);
		alu_result = 8'h05;
		flag_op = FLAG_LOGIC;
		step(OP_INC);
		flags(1'b1, 1'b0);
		irq_vector = 12'($random(seed));
		step(OP_IRQ);
		check("ctx_irq", context_now, CTX_IRQ);
		flags(1'b0, 1'b0);
		tested_bit = 1'b1;
		flag_op = FLAG_BITTEST;
		step(OP_INC);
		flags(1'b1, 1'b0);
		alu_result = 8'h00;
		alu_carry = 1'b0;
		flag_op = FLAG_ARITH;
		step(OP_INC);
		flags(1'b0, 1'b1);
		step(OP_INTERRUPT_EXIT_OP);
		check("ctx_back", context_now, CTX_NMI);
		flags(1'b1, 1'b0);
		dwrite(8'hff, 8'h81);
		flag_op = FLAG_ROTATE;
		step(OP_INC);
		check("rotate", accumulator, 8'h03);
		flags(1'b1, 1'b0);
		step(OP_INTERRUPT_EXIT_OP);
		check("ctx_normal", context_now, CTX_NORMAL);
		flags(1'b0, 1'b0);
		// Random program flow
		for (int i = 0; i < 30; i++)
		begin
			pc_target = 12'($random(seed));
			branch_offset = rom_byte;
			step(ops[$unsigned($random(seed)) % 5]);
		end
		// Overflow past six levels, then unwind past empty
		repeat (7)
		begin
			pc_target = 12'($random(seed));
			step(OP_CALL);
		end
		repeat (8) step(OP_RET);
		pc_target = 12'hfff;
		step(OP_JUMP);
		step(OP_INC);
		check("pc_wrap", program_counter, 12'h000);
		// Nested interrupt then non-maskable entry, unwound in order
		step(OP_IRQ);
		step(OP_NMI);
		check("ctx_nmi", context_now, CTX_NMI);
		step(OP_INTERRUPT_EXIT_OP);
		check("ctx_nest_irq", context_now, CTX_IRQ);
		step(OP_INTERRUPT_EXIT_OP);
		check("ctx_nest_normal", context_now, CTX_NORMAL);
		// Instruction lengths
		for (int l = 0; l < 3; l++)
		begin
			instr_len = instr_len_t'(l);
			instr_start = 1'b1;
			op(OP_HOLD, FLAG_NONE);
			n = 0;
			while (instr_done !== 1'b1 && n < 100)
			begin
				tick();
				n++;
			end
			check("instr_done", 16'(n), 16'((l == 0 ? 1 : l + 2) * 13));
		end
		// Mid-run reset must bring back the vector and the non-maskable context
		reset_n = 1'b0;
		tick();
		check("pc_rst2", program_counter, `RESET_VECTOR_DEFAULT);
		check("ctx_rst2", context_now, CTX_NMI);
		reset_n = 1'b1;
		results();
	end
endmodule : cpu_core_state_registers_tb

`default_nettype wire

// >>> dv/prog_mem_model.sv
// Program memory model feeding fetched bytes back to the core
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model
	import core_state_pkg::*;
(
	// Fetch side
	input wire logic clk,
	input wire logic [11:0] addr,
	output logic [7:0] data
);
	// One cycle of read latency, like a synchronous array; contents are a hash of the address
	always_ff @(posedge clk)
	begin
		data <= addr[7:0] ^ addr[11:4];
	end
endmodule : prog_mem_model

`default_nettype wire

// >>> hw/core_state_params.svh
// Constants for the core register file: addresses, dividers, counts, vectors
`ifndef CORE_STATE_PARAMS_SVH
`define CORE_STATE_PARAMS_SVH

`define ADDR_PTR_FIRST 8'h80
`define ADDR_PTR_SECOND 8'h81
`define ADDR_SD_FIRST 8'h82
`define ADDR_SD_SECOND 8'h83
`define ADDR_ACCUM 8'hff

`define DATA_W 8
`define PC_W 12
`define OFFSET_W 8
`define STACK_LEVELS 6

`define CORE_DIV 13
`define PERIPH_DIV 12
`define DIV_CNT_W 4

`define INSTR_CYC_SHORT 3'h2
`define INSTR_CYC_MID 3'h4
`define INSTR_CYC_LONG 3'h5

`define RESET_VECTOR_DEFAULT 12'hffe
`define NMI_VECTOR_DEFAULT 12'hffc
`define PC_STEP 12'h001
`define DATA_ZERO 8'h00

`endif

// >>> hw/core_state_pkg.sv
// Types shared by the core register file and its return stack
package core_state_pkg;

	// Gray order along normal -> irq -> nmi
	typedef enum logic [1:0]
	{
		CTX_NORMAL = 2'h0,
		CTX_IRQ = 2'h1,
		CTX_NMI = 2'h3
	} context_t;

	typedef enum logic [3:0]
	{
		OP_HOLD = 4'h0,
		OP_INC = 4'h1,
		OP_BRANCH = 4'h2,
		OP_JUMP = 4'h3,
		OP_CALL = 4'h4,
		OP_IRQ = 4'h5,
		OP_NMI = 4'h6,
		OP_RET = 4'h7,
		OP_INTERRUPT_EXIT_OP = 4'h8
	} pc_op_t;

	typedef enum logic [2:0]
	{
		FLAG_NONE = 3'h0,
		FLAG_ARITH = 3'h1,
		FLAG_LOGIC = 3'h2,
		FLAG_BITTEST = 3'h3,
		FLAG_ROTATE = 3'h4
	} flag_op_t;

	typedef enum logic [1:0]
	{
		LEN_SHORT = 2'h0,
		LEN_MID = 2'h1,
		LEN_LONG = 2'h2
	} instr_len_t;

endpackage : core_state_pkg

// >>> hw/cpu_core_state_registers.sv
// Programmer-visible core state: accumulator, pointers, program counter, flags, stack, dividers
// How it works
// RULE_01 - Accumulator also mapped at data address ffh
// RULE_02 - Pointer registers mapped at 80h and 81h
// RULE_03 - Short-direct registers mapped at 82h and 83h
// RULE_04 - Program counter is twelve bits wide
// RULE_05 - Program counter increments by one per fetch
// RULE_06 - Relative branch adds signed offset to counter
// RULE_07 - Jump, call, vectors and returns load counter
// RULE_08 - Three carry/zero pairs, one per context
// RULE_09 - Interrupt entry switches pair, return restores
// RULE_10 - Pairs keep values, reachable only in context
// RULE_11 - Carry from arithmetic, bit test, rotate left
// RULE_12 - Zero set when last result is zero
// RULE_13 - Reset starts in the non-maskable context
// RULE_14 - Six-entry twelve-bit hidden return stack
// RULE_15 - Push shifts levels down, counter enters top
// RULE_16 - Pop loads counter, levels move up
// RULE_17 - Stack saturates; empty return just continues
// RULE_18 - Clock divided by 13 core, 12 peripherals
// RULE_19 - Instructions take two, four or five cycles
// RULE_20 - Data-space and implicit access share registers
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"

module cpu_core_state_registers
	import core_state_pkg::*;
#(
	parameter logic [`PC_W-1:0] RESET_VECTOR = `RESET_VECTOR_DEFAULT,
	parameter logic [`PC_W-1:0] NMI_VECTOR = `NMI_VECTOR_DEFAULT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Data-space access
	input wire logic [7:0] ds_addr,
	input wire logic ds_write,
	input wire logic ds_read,
	input wire logic [`DATA_W-1:0] ds_wdata,
	output logic [`DATA_W-1:0] ds_rdata,
	output logic ds_hit,
	// Program counter control, sampled on machine-cycle ticks
	input wire pc_op_t pc_op,
	input wire logic [`PC_W-1:0] pc_target,
	input wire logic [`PC_W-1:0] irq_vector,
	input wire logic [`OFFSET_W-1:0] branch_offset,
	output logic [`PC_W-1:0] program_counter,
	// Accumulator and flag updates from the ALU
	input wire logic acc_load,
	input wire logic [`DATA_W-1:0] acc_value,
	input wire flag_op_t flag_op,
	input wire logic [`DATA_W-1:0] alu_result,
	input wire logic alu_carry,
	input wire logic tested_bit,
	output logic [`DATA_W-1:0] accumulator,
	output logic carry,
	output logic zero,
	output context_t context_now,
	// Instruction timing
	input wire logic instr_start,
	input wire instr_len_t instr_len,
	output logic machine_cycle,
	output logic periph_tick,
	output logic instr_done
);

	typedef struct packed
	{
		logic [`DATA_W-1:0] acc;
		logic [`DATA_W-1:0] index_pointer_first;
		logic [`DATA_W-1:0] index_pointer_second;
		logic [`DATA_W-1:0] short_direct_first;
		logic [`DATA_W-1:0] short_direct_second;
		logic [`PC_W-1:0] pc;
		logic normal_carry_flag;
		logic normal_zero_flag;
		logic irq_carry_flag;
		logic irq_zero_flag;
		logic nmi_carry_flag;
		logic nmi_zero_flag;
		context_t ctx;
		context_t hist0;
		context_t hist1;
		logic [`DIV_CNT_W-1:0] core_cnt;
		logic [`DIV_CNT_W-1:0] periph_cnt;
		logic mc_tick;
		logic pr_tick;
		logic [2:0] instr_left;
		logic done;
		logic [`DATA_W-1:0] rdata;
		logic hit;
		logic cur_carry;
		logic cur_zero;
	} core_state_t;

	core_state_t st;
	core_state_t next_st;

	logic stack_push;
	logic stack_pop;
	logic [`PC_W-1:0] stack_top;
	logic stack_empty;
	logic c_now;
	logic z_now;
	logic new_c;
	logic new_z;
	logic [`DATA_W-1:0] rot_value;

	////////////////////////////////////////////////////////////////////////////////

	return_stack #(
		.LEVELS(`STACK_LEVELS),
		.WIDTH(`PC_W)
	) u_stack (
		.clk(clk),
		.reset_n(reset_n),
		.push(stack_push), // RULE_14
		.pop(stack_pop),
		.push_data(st.pc),
		.top(stack_top),
		.empty(stack_empty)
	);

	assign stack_push = st.mc_tick && (pc_op == OP_CALL || pc_op == OP_IRQ || pc_op == OP_NMI);
	// An empty stack is never popped, so its contents stay put
	assign stack_pop = st.mc_tick && (pc_op == OP_RET || pc_op == OP_INTERRUPT_EXIT_OP) && !stack_empty;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [2:0] cycles_of(input instr_len_t len);
		unique case (len)
			LEN_SHORT: cycles_of = `INSTR_CYC_SHORT;
			LEN_MID: cycles_of = `INSTR_CYC_MID;
			default: cycles_of = `INSTR_CYC_LONG;
		endcase
	endfunction : cycles_of

	always_comb
	begin
		next_st = st;
		// Only the pair of the active context is visible or written
		unique case (st.ctx)
			CTX_NORMAL: begin c_now = st.normal_carry_flag; z_now = st.normal_zero_flag; end
			CTX_IRQ: begin c_now = st.irq_carry_flag; z_now = st.irq_zero_flag; end
			CTX_NMI: begin c_now = st.nmi_carry_flag; z_now = st.nmi_zero_flag; end
			default: begin c_now = st.normal_carry_flag; z_now = st.normal_zero_flag; end
		endcase // RULE_08 RULE_10
		new_c = c_now;
		new_z = z_now;
		rot_value = {st.acc[`DATA_W-2:0], c_now};

		// Clock dividers
		next_st.mc_tick = (st.core_cnt == `DIV_CNT_W'(`CORE_DIV - 1)); // RULE_18
		next_st.core_cnt = next_st.mc_tick ? '0 : st.core_cnt + `DIV_CNT_W'(1);
		next_st.pr_tick = (st.periph_cnt == `DIV_CNT_W'(`PERIPH_DIV - 1)); // RULE_18
		next_st.periph_cnt = next_st.pr_tick ? '0 : st.periph_cnt + `DIV_CNT_W'(1);

		// Instruction length in machine cycles
		next_st.done = 1'b0;
		if (st.mc_tick)
		begin
			if (instr_start)
			begin
				next_st.instr_left = cycles_of(instr_len) - 3'h1; // RULE_19
			end
			else if (st.instr_left != 3'h0)
			begin
				next_st.instr_left = st.instr_left - 3'h1;
				next_st.done = (st.instr_left == 3'h1); // RULE_19
			end
		end

		// Accumulator from the ALU; a data-space write below overrides it
		if (st.mc_tick && acc_load)
		begin
			next_st.acc = acc_value; // RULE_20
		end

		if (st.mc_tick)
		begin
			unique case (flag_op)
				FLAG_ARITH:
				begin
					new_c = alu_carry; // RULE_11
					new_z = (alu_result == `DATA_ZERO); // RULE_12
				end
				FLAG_LOGIC: new_z = (alu_result == `DATA_ZERO); // RULE_12
				FLAG_BITTEST: new_c = tested_bit; // RULE_11
				FLAG_ROTATE:
				begin
					// Rotate left through carry acts on the accumulator itself
					new_c = st.acc[`DATA_W-1]; // RULE_11
					new_z = (rot_value == `DATA_ZERO); // RULE_12
					next_st.acc = rot_value;
				end
				FLAG_NONE: ;
				default: ;
			endcase
		end
		unique case (st.ctx)
			CTX_NORMAL: begin next_st.normal_carry_flag = new_c; next_st.normal_zero_flag = new_z; end
			CTX_IRQ: begin next_st.irq_carry_flag = new_c; next_st.irq_zero_flag = new_z; end
			CTX_NMI: begin next_st.nmi_carry_flag = new_c; next_st.nmi_zero_flag = new_z; end
			default: ;
		endcase // RULE_08

		// Program counter and context switching
		if (st.mc_tick)
		begin
			unique case (pc_op)
				OP_INC: next_st.pc = st.pc + `PC_STEP; // RULE_05
				OP_BRANCH: next_st.pc = st.pc + {{(`PC_W-`OFFSET_W){branch_offset[`OFFSET_W-1]}},
					branch_offset}; // RULE_06
				OP_JUMP, OP_CALL: next_st.pc = pc_target; // RULE_07
				OP_IRQ, OP_NMI:
				begin
					next_st.pc = (pc_op == OP_IRQ) ? irq_vector : NMI_VECTOR; // RULE_07
					next_st.ctx = (pc_op == OP_IRQ) ? CTX_IRQ : CTX_NMI; // RULE_09
					next_st.hist0 = st.ctx;
					next_st.hist1 = st.hist0;
				end
				OP_RET, OP_INTERRUPT_EXIT_OP:
				begin
					// Empty stack: counter already names the next instruction
					if (!stack_empty)
					begin
						next_st.pc = stack_top; // RULE_07 RULE_16 RULE_17
					end
					if (pc_op == OP_INTERRUPT_EXIT_OP)
					begin
						next_st.ctx = st.hist0; // RULE_09
						next_st.hist0 = st.hist1;
						next_st.hist1 = CTX_NORMAL;
					end
				end
				OP_HOLD: ;
				default: ;
			endcase
		end

		// Data-space port shares the physical registers
		if (ds_write)
		begin
			unique case (ds_addr)
				`ADDR_ACCUM: next_st.acc = ds_wdata; // RULE_01 RULE_20
				`ADDR_PTR_FIRST: next_st.index_pointer_first = ds_wdata; // RULE_02
				`ADDR_PTR_SECOND: next_st.index_pointer_second = ds_wdata; // RULE_02
				`ADDR_SD_FIRST: next_st.short_direct_first = ds_wdata; // RULE_03
				`ADDR_SD_SECOND: next_st.short_direct_second = ds_wdata; // RULE_03
				default: ;
			endcase
		end
		next_st.hit = 1'b0;
		next_st.rdata = `DATA_ZERO;
		if (ds_read)
		begin
			next_st.hit = 1'b1;
			unique case (ds_addr)
				`ADDR_ACCUM: next_st.rdata = st.acc; // RULE_01
				`ADDR_PTR_FIRST: next_st.rdata = st.index_pointer_first; // RULE_02
				`ADDR_PTR_SECOND: next_st.rdata = st.index_pointer_second; // RULE_02
				`ADDR_SD_FIRST: next_st.rdata = st.short_direct_first; // RULE_03
				`ADDR_SD_SECOND: next_st.rdata = st.short_direct_second; // RULE_03
				default: next_st.hit = 1'b0;
			endcase
		end

		// Registered view of the pair that the next context will use
		unique case (next_st.ctx)
			CTX_NORMAL: begin next_st.cur_carry = next_st.normal_carry_flag;
				next_st.cur_zero = next_st.normal_zero_flag; end
			CTX_IRQ: begin next_st.cur_carry = next_st.irq_carry_flag;
				next_st.cur_zero = next_st.irq_zero_flag; end
			CTX_NMI: begin next_st.cur_carry = next_st.nmi_carry_flag;
				next_st.cur_zero = next_st.nmi_zero_flag; end
			default: begin next_st.cur_carry = 1'b0; next_st.cur_zero = 1'b0; end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= '0;
			st.pc <= RESET_VECTOR; // RULE_07
			st.ctx <= CTX_NMI; // RULE_13
			st.hist0 <= CTX_NORMAL;
			st.hist1 <= CTX_NORMAL;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign ds_rdata = st.rdata;
	assign ds_hit = st.hit;
	assign program_counter = st.pc; // RULE_04
	assign accumulator = st.acc;
	assign carry = st.cur_carry;
	assign zero = st.cur_zero;
	assign context_now = st.ctx;
	assign machine_cycle = st.mc_tick;
	assign periph_tick = st.pr_tick;
	assign instr_done = st.done;

	////////////////////////////////////////////////////////////////////////////////

	a_acc_data_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
		ds_write && ds_addr == `ADDR_ACCUM |=> st.acc == $past(ds_wdata))
		else $error("accumulator missed a data-space write");

	a_ptr_read_back: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
		ds_read && ds_addr == `ADDR_PTR_SECOND |=> ds_hit && ds_rdata == $past(st.index_pointer_second))
		else $error("pointer read returned wrong data");

	a_sd_data_write: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
		ds_write && ds_addr == `ADDR_SD_FIRST |=> st.short_direct_first == $past(ds_wdata))
		else $error("short-direct register missed a write");

	a_pc_increment: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
		st.mc_tick && pc_op == OP_INC |=> st.pc == $past(st.pc) + `PC_STEP)
		else $error("counter did not step by one");

	a_branch_sum: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
		st.mc_tick && pc_op == OP_BRANCH |=> st.pc == $past(st.pc)
			+ {{(`PC_W-`OFFSET_W){$past(branch_offset[`OFFSET_W-1])}}, $past(branch_offset)})
		else $error("branch target wrong");

	a_irq_entry: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
		st.mc_tick && pc_op == OP_IRQ |=> st.pc == $past(irq_vector) && st.ctx == CTX_IRQ)
		else $error("interrupt entry did not load vector and context");

	a_ctx_restore: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
		st.mc_tick && pc_op == OP_INTERRUPT_EXIT_OP |=> st.ctx == $past(st.hist0))
		else $error("interrupt return did not restore context");

	a_flags_retained: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
		st.ctx != CTX_NORMAL |=> $stable(st.normal_carry_flag) && $stable(st.normal_zero_flag))
		else $error("normal flags changed outside their context");

	a_zero_arith: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
		st.mc_tick && flag_op == FLAG_ARITH && pc_op != OP_IRQ && pc_op != OP_NMI && pc_op != OP_INTERRUPT_EXIT_OP
			|=> zero == ($past(alu_result) == `DATA_ZERO) && carry == $past(alu_carry))
		else $error("arithmetic flags wrong");

	a_core_divide: assert property (@(posedge clk) disable iff (!reset_n) // RULE_18
		st.mc_tick |=> !st.mc_tick [*8] ##1 !st.mc_tick ##1 !st.mc_tick ##1 !st.mc_tick
			##1 !st.mc_tick ##1 st.mc_tick)
		else $error("machine cycle is not thirteen clocks");

	a_periph_divide: assert property (@(posedge clk) disable iff (!reset_n) // RULE_18
		st.pr_tick |-> ##12 st.pr_tick)
		else $error("peripheral tick is not twelve clocks");

	a_instr_short: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
		st.mc_tick && instr_start && instr_len == LEN_SHORT |-> ##14 st.done)
		else $error("short instruction not done after two cycles");

	c_call_return: cover property (@(posedge clk) disable iff (!reset_n)
		st.mc_tick && pc_op == OP_CALL ##[1:100] st.mc_tick && pc_op == OP_RET);
	c_irq_nested_nmi: cover property (@(posedge clk) disable iff (!reset_n)
		st.ctx == CTX_IRQ ##[1:100] st.ctx == CTX_NMI);
	c_rotate: cover property (@(posedge clk) disable iff (!reset_n)
		st.mc_tick && flag_op == FLAG_ROTATE);
	c_empty_return: cover property (@(posedge clk) disable iff (!reset_n)
		st.mc_tick && pc_op == OP_RET && stack_empty);

endmodule : cpu_core_state_registers
`default_nettype wire

// >>> hw/return_stack.sv
// Six-level shifting return stack with saturating depth
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"

module return_stack
	import core_state_pkg::*;
#(
	parameter int LEVELS = `STACK_LEVELS,
	parameter int WIDTH = `PC_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Stack commands
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] push_data,
	// Stack view
	output logic [WIDTH-1:0] top,
	output logic empty
);

	localparam int DEPTH_W = $clog2(LEVELS + 1);
	localparam logic [DEPTH_W-1:0] FULL = DEPTH_W'(LEVELS);

	typedef struct packed
	{
		logic [LEVELS-1:0][WIDTH-1:0] level;
		logic [DEPTH_W-1:0] depth;
	} stack_state_t;

	stack_state_t st;
	stack_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_st = st;
		if (push)
		begin
			// Oldest entry falls off the bottom
			next_st.level[0] = push_data; // RULE_15
			for (int i = 1; i < LEVELS; i++)
			begin
				next_st.level[i] = st.level[i-1]; // RULE_15
			end
			if (st.depth != FULL)
			begin
				next_st.depth = st.depth + DEPTH_W'(1); // RULE_17
			end
		end
		else if (pop)
		begin
			for (int i = 0; i < LEVELS - 1; i++)
			begin
				next_st.level[i] = st.level[i+1]; // RULE_16
			end
			next_st.level[LEVELS-1] = '0;
			if (st.depth != '0)
			begin
				next_st.depth = st.depth - DEPTH_W'(1); // RULE_17
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign top = st.level[0];
	assign empty = (st.depth == '0);

	////////////////////////////////////////////////////////////////////////////////

	a_stack_saturate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
		push && st.depth == FULL |=> st.depth == FULL)
		else $error("stack depth passed six levels");

	a_stack_push_shift: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
		push |=> st.level[0] == $past(push_data) && st.level[1] == $past(st.level[0]))
		else $error("push did not shift the stack");

	a_stack_pop_shift: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
		pop && !push |=> st.level[0] == $past(st.level[1]))
		else $error("pop did not move levels up");

endmodule : return_stack
`default_nettype wire
